// ===== verilog/pscd_pkg.sv
// ****************************************
// shared constants for both ends
// ****************************************
package pscd_pkg;
  // timing
  localparam int CLK_NS = 10;
  localparam int LINK_CLK_NS = 120;
  localparam int QUARTER_CYC = LINK_CLK_NS / CLK_NS / 4;
  localparam int NV_WRITE_NS = 5000;
  localparam int NV_WRITE_CYC = NV_WRITE_NS / CLK_NS;
  // target address and byte layout
  localparam logic [4:0] ADDR_FIXED = 5'h0B;
  localparam int CMD_LOC_LO = 4;
  localparam int CMD_OP_LO = 2;
  localparam int CMD_NINTH = 0;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  // locations
  localparam logic [3:0] LOC_W0 = 4'h0;
  localparam logic [3:0] LOC_W1 = 4'h1;
  localparam logic [3:0] LOC_NV0 = 4'h2;
  localparam logic [3:0] LOC_NV1 = 4'h3;
  localparam logic [3:0] LOC_TERM_CTRL = 4'h4;
  localparam logic [3:0] LOC_STAT = 4'h5;
  localparam logic [3:0] LOC_W2 = 4'h6;
  localparam int NUM_LOC = 7;
  // operation field codes
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_INC = 2'h1;
  localparam logic [1:0] OP_DEC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  // values
  localparam logic [9:0] FULL_SCALE = 10'h100;
  localparam logic [9:0] MID_SCALE = 10'h080;
  localparam logic [9:0] TERM_CTRL_RST = 10'h1FF;
  // host register map and actions
  localparam logic [1:0] HREG_ACT = 2'h0;
  localparam logic [1:0] HREG_STAT = 2'h1;
  localparam logic [1:0] HREG_HV = 2'h2;
  localparam logic [2:0] ACT_START = 3'h1;
  localparam logic [2:0] ACT_STOP = 3'h2;
  localparam logic [2:0] ACT_WRITE = 3'h3;
  localparam logic [2:0] ACT_READ_ACK = 3'h4;
  localparam logic [2:0] ACT_READ_NACK = 3'h5;
  typedef enum logic [2:0] {P_IDLE, P_ADDR, P_CMD, P_DATA, P_TX, P_ERR} pscd_dev_ph_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} pscd_host_ph_t;
endpackage

// ===== verilog/pscd_link_if.sv
`timescale 1ns/10ps
// ****************************************
// two-wire link between host and target
// ****************************************
interface pscd_link_if;
  logic scl;
  logic hv;
  logic host_sda_o;
  logic host_sda_oen;
  logic dev_sda_o;
  logic dev_sda_oen;
  logic sda;
  // open-drain wired and, released line reads high
  assign sda = (host_sda_oen | host_sda_o) & (dev_sda_oen | dev_sda_o);
  modport host (output scl, output hv, output host_sda_o, output host_sda_oen, input sda);
  modport dev (input scl, input hv, input sda, output dev_sda_o, output dev_sda_oen);
endinterface

// ===== verilog/pscd_target.sv
`timescale 1ns/10ps
// Overview of operation
// - volatile wipers take write, read, step
// - saved wipers and terminal control: write, read
// - write/read framing lengths; continuous write volatile
// - step framing lengths; volatile only
// - high-voltage pin level marks command type
// - high-voltage decrement on saved wipers sets lock, increment clears it
// - command byte: location, operation, two data
// - four-bit location, two-bit operation select
// - increment adds one up to full scale, decrement subtracts one down to zero
// - steps elsewhere are invalid combinations
// - invalid pair gets not-acknowledge
// - master sends start after reject
// - command data bit 0 is wiper bit 8, bit 9 written zero
// - location five is read only
// - high-voltage step on saved wiper 0 lock
// - high-voltage step on saved wiper 1 lock
// - reads accepted while saved write busy
// - write joins ninth bit with data byte
// - read returns two bytes, ten bits
// - start or stop mid-data aborts write
// - address: fixed five bits plus pins
module pscd_target
  import pscd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  pscd_link_if.dev link,
  input wire logic board_addr_pin_hi,
  input wire logic board_addr_pin_lo,
  output logic [9:0] wiper0_live,
  output logic [9:0] wiper1_live,
  output logic [9:0] wiper2_live,
  output logic [9:0] wiper0_saved,
  output logic [9:0] wiper1_saved,
  output logic [9:0] terminal_connect_ctrl0,
  output logic lock0,
  output logic lock1,
  output logic nv_busy
);
  typedef struct packed {
    pscd_dev_ph_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] txsh;
    logic ack;
    logic sda_oen;
    logic sdo;
    logic ninth;
    logic bsel;
    logic [3:0] ptr;
    logic [NUM_LOC-1:0][9:0] loc;
    logic lock0;
    logic lock1;
    logic busy;
    logic [12:0] busy_cnt;
    logic [1:0] pin_cnt;
    logic [1:0] pins;
    logic [1:0] pin1;
    logic [1:0] pin2;
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic hv1;
    logic hv2;
  } pscd_dev_st_t;

  pscd_dev_st_t st_r;
  pscd_dev_st_t st_nxt;

  // ****************************************
  // command checks and value helpers
  // ****************************************
  function automatic logic legal(input logic [3:0] l, input logic [1:0] op, input logic hv,
                                 input logic bsy, input logic lk0, input logic lk1);
    logic ok;
    ok = 1'b0;
    case (l)
      LOC_W0, LOC_W1, LOC_W2: ok = 1'b1;
      LOC_NV0: ok = (op == OP_READ) || (op == OP_WRITE && !bsy && !lk0) ||
                    ((op == OP_INC || op == OP_DEC) && hv);
      LOC_NV1: ok = (op == OP_READ) || (op == OP_WRITE && !bsy && !lk1) ||
                    ((op == OP_INC || op == OP_DEC) && hv);
      LOC_TERM_CTRL: ok = (op == OP_READ) || (op == OP_WRITE);
      LOC_STAT: ok = (op == OP_READ);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [9:0] step(input logic [9:0] v, input logic up);
    logic [9:0] res;
    res = v;
    if (up && v < FULL_SCALE)
      res = v + 10'h001;
    else if (!up && v != 10'h000)
      res = v - 10'h001;
    return res;
  endfunction

  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic [7:0] bytev;
  logic [9:0] rdv;
  logic [3:0] cloc;
  logic [1:0] cop;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    // two-flop synchronisers, third stage for edges
    st_nxt.scl1 = link.scl;
    st_nxt.scl2 = st_r.scl1;
    st_nxt.scl3 = st_r.scl2;
    st_nxt.sda1 = link.sda;
    st_nxt.sda2 = st_r.sda1;
    st_nxt.sda3 = st_r.sda2;
    st_nxt.hv1 = link.hv;
    st_nxt.hv2 = st_r.hv1;
    st_nxt.pin1 = {board_addr_pin_hi, board_addr_pin_lo};
    st_nxt.pin2 = st_r.pin1;
    rise = st_r.scl2 & ~st_r.scl3;
    fall = ~st_r.scl2 & st_r.scl3;
    start_c = st_r.scl2 & st_r.scl3 & st_r.sda3 & ~st_r.sda2;
    stop_c = st_r.scl2 & st_r.scl3 & ~st_r.sda3 & st_r.sda2;
    bytev = {st_r.sh[6:0], st_r.sda2};
    cloc = bytev[CMD_LOC_LO +: 4];
    cop = bytev[CMD_OP_LO +: 2];
    // status location shows locks and busy
    rdv = (st_r.ptr == LOC_STAT) ? {7'h00, st_r.busy, st_r.lock1, st_r.lock0}
                                 : st_r.loc[st_r.ptr[2:0]];
    // address pins caught a few cycles after reset release
    if (st_r.pin_cnt != 2'h3)
    begin
      st_nxt.pin_cnt = st_r.pin_cnt + 2'h1;
      st_nxt.pins = st_r.pin2;
    end
    // saved-wiper write busy timer
    if (st_r.busy_cnt != 13'h0000)
      st_nxt.busy_cnt = st_r.busy_cnt - 13'h0001;
    st_nxt.busy = (st_nxt.busy_cnt != 13'h0000);
    // start restarts, stop idles, pending data dropped
    if (start_c)
    begin
      st_nxt.ph = P_ADDR;
      st_nxt.cnt = 4'h0;
      st_nxt.ack = 1'b0;
      st_nxt.sda_oen = 1'b1;
    end
    else if (stop_c)
    begin
      st_nxt.ph = P_IDLE;
      st_nxt.sda_oen = 1'b1;
    end
    else if (st_r.ph != P_IDLE && st_r.ph != P_ERR)
    begin
      // drive on falling edge: ack slot or transmit bit
      if (fall)
      begin
        if (st_r.cnt == BIT_ACK)
          st_nxt.sda_oen = ~st_r.ack;
        else
          st_nxt.sda_oen = ~((st_r.ph == P_TX) & ~st_r.txsh[3'(BIT_LAST - st_r.cnt)]);
      end
      if (rise && st_r.cnt == BIT_ACK)
      begin
        st_nxt.cnt = 4'h0;
        st_nxt.ack = 1'b0;
        // master ack repeats the two-byte read
        if (st_r.ph == P_TX && !st_r.ack)
        begin
          if (st_r.sda2)
            st_nxt.ph = P_IDLE;
          else
          begin
            st_nxt.bsel = ~st_r.bsel;
            st_nxt.txsh = st_r.bsel ? {6'h00, rdv[9:8]} : rdv[7:0];
          end
        end
      end
      else if (rise)
      begin
        st_nxt.cnt = st_r.cnt + 4'h1;
        st_nxt.sh = bytev;
        if (st_r.cnt == BIT_LAST && st_r.ph != P_TX)
        begin
          st_nxt.ack = 1'b0;
          case (st_r.ph)
            P_ADDR:
            begin
              if (bytev[7:1] == {ADDR_FIXED, st_r.pins})
              begin
                st_nxt.ack = 1'b1;
                st_nxt.ph = bytev[0] ? P_TX : P_CMD;
                st_nxt.bsel = 1'b0;
                st_nxt.txsh = {6'h00, rdv[9:8]};
              end
              else
                st_nxt.ph = P_IDLE;
            end
            P_CMD:
            begin
              if (legal(cloc, cop, st_r.hv2, st_r.busy, st_r.lock0, st_r.lock1))
              begin
                st_nxt.ack = 1'b1;
                st_nxt.ptr = cloc;
                st_nxt.ninth = bytev[CMD_NINTH];
                if (cop == OP_WRITE)
                  st_nxt.ph = P_DATA;
                else if (cloc == LOC_NV0 && cop != OP_READ)
                  st_nxt.lock0 = (cop == OP_DEC);
                else if (cloc == LOC_NV1 && cop != OP_READ)
                  st_nxt.lock1 = (cop == OP_DEC);
                else if (cop != OP_READ)
                  st_nxt.loc[cloc[2:0]] = step(st_r.loc[cloc[2:0]], cop == OP_INC);
              end
              else
              begin
                st_nxt.ph = P_ERR;
              end
            end
            P_DATA:
            begin
              // ninth bit on top of data byte
              st_nxt.loc[st_r.ptr[2:0]] = {1'b0, st_r.ninth, bytev};
              st_nxt.ack = 1'b1;
              st_nxt.ph = P_CMD;
              if (st_r.ptr == LOC_NV0 || st_r.ptr == LOC_NV1)
              begin
                st_nxt.busy_cnt = 13'(NV_WRITE_CYC);
                st_nxt.busy = 1'b1;
              end
            end
            default: st_nxt.ack = 1'b0;
          endcase
        end
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.ph <= P_IDLE;
      st_r.sda_oen <= 1'b1;
      st_r.scl1 <= 1'b1;
      st_r.scl2 <= 1'b1;
      st_r.scl3 <= 1'b1;
      st_r.sda1 <= 1'b1;
      st_r.sda2 <= 1'b1;
      st_r.sda3 <= 1'b1;
      st_r.loc[LOC_W0[2:0]] <= MID_SCALE;
      st_r.loc[LOC_W1[2:0]] <= MID_SCALE;
      st_r.loc[LOC_W2[2:0]] <= MID_SCALE;
      st_r.loc[LOC_NV0[2:0]] <= MID_SCALE;
      st_r.loc[LOC_NV1[2:0]] <= MID_SCALE;
      st_r.loc[LOC_TERM_CTRL[2:0]] <= TERM_CTRL_RST;
    end
    else
      st_r <= st_nxt;
  end

  // outputs straight from state
  assign link.dev_sda_o = st_r.sdo;
  assign link.dev_sda_oen = st_r.sda_oen;
  assign wiper0_live = st_r.loc[LOC_W0[2:0]];
  assign wiper1_live = st_r.loc[LOC_W1[2:0]];
  assign wiper2_live = st_r.loc[LOC_W2[2:0]];
  assign wiper0_saved = st_r.loc[LOC_NV0[2:0]];
  assign wiper1_saved = st_r.loc[LOC_NV1[2:0]];
  assign terminal_connect_ctrl0 = st_r.loc[LOC_TERM_CTRL[2:0]];
  assign lock0 = st_r.lock0;
  assign lock1 = st_r.lock1;
  assign nv_busy = st_r.busy;
endmodule

// ===== verilog/pscd_master.sv
`timescale 1ns/10ps
module pscd_master
  import pscd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  pscd_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  typedef struct packed {
    pscd_host_ph_t ph;
    logic [1:0] q;
    logic [3:0] qc;
    logic [3:0] bi;
    logic [8:0] tx9;
    logic [8:0] rx9;
    logic nack;
    logic scl;
    logic sda_oen;
    logic sdo;
    logic hv;
    logic sda1;
    logic sda2;
    logic [15:0] rdata;
  } pscd_host_st_t;

  pscd_host_st_t st_r;
  pscd_host_st_t st_nxt;
  logic tick;

  // ****************************************
  // register port and bus sequencer
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sda1 = link.sda;
    st_nxt.sda2 = st_r.sda1;
    tick = (st_r.qc == 4'(QUARTER_CYC - 1));
    st_nxt.qc = (st_r.ph == H_IDLE || tick) ? 4'h0 : st_r.qc + 4'h1;
    // read data valid only the cycle after the strobe
    st_nxt.rdata = 16'h0000;
    if (rd)
    begin
      case (addr)
        HREG_STAT: st_nxt.rdata = {6'h00, st_r.ph != H_IDLE, st_r.nack, st_r.rx9[8:1]};
        HREG_HV: st_nxt.rdata = {15'h0000, st_r.hv};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    if (wr && addr == HREG_HV)
      st_nxt.hv = wdata[0];
    // actions accepted only while idle
    if (wr && addr == HREG_ACT && st_r.ph == H_IDLE)
    begin
      st_nxt.q = 2'h0;
      st_nxt.bi = 4'h0;
      case (wdata[10:8])
        ACT_START: st_nxt.ph = H_START;
        ACT_STOP: st_nxt.ph = H_STOP;
        ACT_WRITE:
        begin
          st_nxt.ph = H_BIT;
          st_nxt.tx9 = {wdata[7:0], 1'b1};
        end
        ACT_READ_ACK:
        begin
          st_nxt.ph = H_BIT;
          st_nxt.tx9 = 9'h1FE;
        end
        ACT_READ_NACK:
        begin
          st_nxt.ph = H_BIT;
          st_nxt.tx9 = 9'h1FF;
        end
        default: st_nxt.ph = H_IDLE;
      endcase
    end
    else if (st_r.ph != H_IDLE && tick)
    begin
      st_nxt.q = st_r.q + 2'h1;
      case (st_r.ph)
        // start resets the target after a reject
        H_START:
        begin
          case (st_r.q)
            2'h0: st_nxt.sda_oen = 1'b1;
            2'h1: st_nxt.scl = 1'b1;
            2'h2: st_nxt.sda_oen = 1'b0;
            default:
            begin
              st_nxt.scl = 1'b0;
              st_nxt.ph = H_IDLE;
            end
          endcase
        end
        H_BIT:
        begin
          case (st_r.q)
            2'h0: st_nxt.sda_oen = st_r.tx9[8];
            2'h1: st_nxt.scl = 1'b1;
            2'h2: st_nxt.rx9 = {st_r.rx9[7:0], st_r.sda2};
            default:
            begin
              st_nxt.scl = 1'b0;
              st_nxt.tx9 = {st_r.tx9[7:0], 1'b1};
              st_nxt.bi = st_r.bi + 4'h1;
              if (st_r.bi == BIT_ACK)
              begin
                st_nxt.nack = st_r.rx9[0];
                st_nxt.ph = H_IDLE;
              end
            end
          endcase
        end
        H_STOP:
        begin
          case (st_r.q)
            2'h0: st_nxt.sda_oen = 1'b0;
            2'h1: st_nxt.scl = 1'b1;
            2'h2: st_nxt.sda_oen = 1'b1;
            default: st_nxt.ph = H_IDLE;
          endcase
        end
        default: st_nxt.ph = H_IDLE;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.ph <= H_IDLE;
      st_r.scl <= 1'b1;
      st_r.sda_oen <= 1'b1;
      st_r.sda1 <= 1'b1;
      st_r.sda2 <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign link.scl = st_r.scl;
  assign link.hv = st_r.hv;
  assign link.host_sda_o = st_r.sdo;
  assign link.host_sda_oen = st_r.sda_oen;
  assign rdata = st_r.rdata;
endmodule

// ===== sim/pscd_chk.sv
`timescale 1ns/10ps
// ****************************************
// link timing checker
// ****************************************
module pscd_chk
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl,
  input wire logic hv,
  input wire logic host_sda_o,
  input wire logic host_sda_oen,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oen,
  input wire logic sda
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_reset_idle: assert property ($rose(rstn) |-> scl && host_sda_oen && dev_sda_oen && !hv)
    else $error("link not idle after reset");
  a_drive_low: assert property (!host_sda_o && !dev_sda_o)
    else $error("data line driven high");
  a_scl_high_len: assert property ($rose(scl) |-> scl [*6])
    else $error("clock high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> !scl [*6])
    else $error("clock low phase too short");
  // target holds its bit while clock high
  a_dev_stable_hi: assert property ($rose(scl) |=> $stable(dev_sda_oen) [*5])
    else $error("target data moved while clock high");
  // target changes only after a clock fall
  a_dev_change_lo: assert property ($changed(dev_sda_oen) |-> !scl && !$past(scl))
    else $error("target data moved near clock high");
  a_start_shape: assert property ($fell(host_sda_oen) && scl |-> scl [*3] ##1 !scl)
    else $error("start condition malformed");
  a_stop_idle: assert property ($rose(host_sda_oen) && scl |-> scl [*8])
    else $error("clock moved after stop");

  // main scenarios reached
  c_ack: cover property ($fell(dev_sda_oen));
  c_hv: cover property ($rose(hv));
  c_start: cover property ($fell(host_sda_oen) && scl && !sda);
endmodule

// ===== sim/pscd_bench.sv
`timescale 1ns/10ps
// ****************************************
// bench: master and target face to face
// ****************************************
module pscd_bench
  import pscd_pkg::*;
;
  logic clock = 1'b0;
  logic rstn, pin_hi, pin_lo, wr, rd;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, st;
  logic [9:0] w0, w1, w2, s0, s1, tc;
  logic lock0, lock1, nv_busy;
  int mismatches, checks, cycles;

  pscd_link_if link ();
  pscd_master pscd_master_i (.clock(clock), .rstn(rstn), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  pscd_target pscd_target_i (.clock(clock), .rstn(rstn), .link(link),
    .board_addr_pin_hi(pin_hi), .board_addr_pin_lo(pin_lo), .wiper0_live(w0),
    .wiper1_live(w1), .wiper2_live(w2), .wiper0_saved(s0), .wiper1_saved(s1),
    .terminal_connect_ctrl0(tc), .lock0(lock0), .lock1(lock1), .nv_busy(nv_busy));
  pscd_chk pscd_chk_i (.clock(clock), .rstn(rstn), .scl(link.scl), .hv(link.hv),
    .host_sda_o(link.host_sda_o), .host_sda_oen(link.host_sda_oen),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oen(link.dev_sda_oen), .sda(link.sda));

  // clock and hang guard
  always #(CLK_NS / 2) clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      give_verdict;
    end
  end

  task give_verdict;
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks++;
    if (got !== ex)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one-cycle register strobes
  task reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task reg_rd(input logic [1:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    st = rdata;
  endtask

  // issue a link action and poll until done
  task act(input logic [2:0] c, input logic [7:0] b);
    reg_wr(HREG_ACT, {5'h00, c, b});
    for (int n = 0; n < 400; n++)
    begin
      reg_rd(HREG_STAT);
      if (st[9] === 1'b0)
        break;
    end
  endtask

  task wb(input logic [7:0] b, input logic nk);
    act(ACT_WRITE, b);
    chk("ack slot", {15'h0000, nk}, {15'h0000, st[8]});
  endtask

  task rb(input logic last, input logic [7:0] ex);
    act(last ? ACT_READ_NACK : ACT_READ_ACK, 8'h00);
    chk("read byte", {8'h00, ex}, {8'h00, st[7:0]});
  endtask

  function automatic logic [7:0] cb(input logic [3:0] loc, input logic [1:0] op, input logic top);
    return {loc, op, 1'b0, top};
  endfunction

  task open_cmd(input logic [7:0] c, input logic nk);
    act(ACT_START, 8'h00);
    wb({ADDR_FIXED, pin_hi, pin_lo, 1'b0}, 1'b0);
    wb(c, nk);
  endtask

  task t_write;
    open_cmd(cb(LOC_W0, OP_WRITE, 1'b1), 1'b0);
    wb(8'h23, 1'b0);
    wb(cb(LOC_W2, OP_WRITE, 1'b0), 1'b0);
    wb(8'hC5, 1'b0);
    act(ACT_STOP, 8'h00);
    chk("wiper0_live", 16'h0123, {6'h00, w0});
    chk("wiper2_live", 16'h00C5, {6'h00, w2});
  endtask

  task t_steps;
    open_cmd(cb(LOC_W1, OP_WRITE, 1'b1), 1'b0);
    wb(8'h00, 1'b0);
    wb(cb(LOC_W1, OP_INC, 1'b0), 1'b0);
    act(ACT_STOP, 8'h00);
    chk("wiper1_live", {6'h00, FULL_SCALE}, {6'h00, w1});
    open_cmd(cb(LOC_W1, OP_DEC, 1'b0), 1'b0);
    wb(cb(LOC_W1, OP_DEC, 1'b0), 1'b0);
    act(ACT_STOP, 8'h00);
    chk("wiper1_live", 16'h00FE, {6'h00, w1});
    open_cmd(cb(LOC_W2, OP_WRITE, 1'b0), 1'b0);
    wb(8'h00, 1'b0);
    wb(cb(LOC_W2, OP_DEC, 1'b0), 1'b0);
    wb(cb(LOC_W2, OP_INC, 1'b0), 1'b0);
    act(ACT_STOP, 8'h00);
    chk("wiper2_live", 16'h0001, {6'h00, w2});
  endtask

  // illegal pairs, then everything ignored until start
  task t_illegal;
    logic [3:0] lc [7] = '{LOC_NV0, LOC_NV1, LOC_TERM_CTRL, LOC_TERM_CTRL, LOC_STAT, LOC_STAT,
                           4'h7};
    logic [1:0] oc [7] = '{OP_INC, OP_DEC, OP_INC, OP_DEC, OP_WRITE, OP_INC, OP_READ};
    for (int i = 0; i < 7; i++)
    begin
      open_cmd(cb(lc[i], oc[i], 1'b0), 1'b1);
      wb(cb(LOC_W0, OP_INC, 1'b0), 1'b1);
      act(ACT_STOP, 8'h00);
    end
    chk("wiper0_live", 16'h0123, {6'h00, w0});
  endtask

  task t_locks;
    reg_wr(HREG_HV, 16'h0001);
    reg_rd(HREG_HV);
    chk("hv reg", 16'h0001, st);
    open_cmd(cb(LOC_NV0, OP_DEC, 1'b0), 1'b0);
    wb(cb(LOC_NV1, OP_DEC, 1'b0), 1'b0);
    act(ACT_STOP, 8'h00);
    chk("locks", 16'h0003, {14'h0000, lock1, lock0});
    reg_wr(HREG_HV, 16'h0000);
    open_cmd(cb(LOC_NV0, OP_WRITE, 1'b0), 1'b1);
    act(ACT_STOP, 8'h00);
    open_cmd(cb(LOC_NV1, OP_INC, 1'b0), 1'b1);
    act(ACT_STOP, 8'h00);
    reg_wr(HREG_HV, 16'h0001);
    open_cmd(cb(LOC_NV0, OP_INC, 1'b0), 1'b0);
    wb(cb(LOC_NV1, OP_INC, 1'b0), 1'b0);
    act(ACT_STOP, 8'h00);
    reg_wr(HREG_HV, 16'h0000);
    chk("locks", 16'h0000, {14'h0000, lock1, lock0});
    chk("wiper0_saved", {6'h00, MID_SCALE}, {6'h00, s0});
  endtask

  // saved write, then reads while it runs
  task t_nv;
    open_cmd(cb(LOC_NV1, OP_WRITE, 1'b1), 1'b0);
    wb(8'hAB, 1'b0);
    wb(cb(LOC_STAT, OP_READ, 1'b0), 1'b0);
    chk("nv_busy", 16'h0001, {15'h0000, nv_busy});
    act(ACT_START, 8'h00);
    wb({ADDR_FIXED, pin_hi, pin_lo, 1'b1}, 1'b0);
    rb(1'b0, 8'h00);
    act(ACT_READ_NACK, 8'h00);
    chk("lock bits", 16'h0000, {14'h0000, st[1:0]});
    act(ACT_STOP, 8'h00);
    for (int n = 0; n < 600 && nv_busy !== 1'b0; n++)
      @(posedge clock);
    chk("wiper1_saved", 16'h01AB, {6'h00, s1});
  endtask

  task t_read;
    open_cmd(cb(LOC_TERM_CTRL, OP_WRITE, 1'b1), 1'b0);
    wb(8'h5A, 1'b0);
    wb(cb(LOC_TERM_CTRL, OP_READ, 1'b0), 1'b0);
    act(ACT_START, 8'h00);
    wb({ADDR_FIXED, pin_hi, pin_lo, 1'b1}, 1'b0);
    rb(1'b0, 8'h01);
    rb(1'b0, 8'h5A);
    rb(1'b0, 8'h01);
    rb(1'b1, 8'h5A);
    act(ACT_STOP, 8'h00);
    chk("terminal_connect_ctrl0", 16'h015A, {6'h00, tc});
  endtask

  task t_abort;
    open_cmd(cb(LOC_W1, OP_WRITE, 1'b1), 1'b0);
    act(ACT_STOP, 8'h00);
    open_cmd(cb(LOC_W1, OP_WRITE, 1'b0), 1'b0);
    act(ACT_START, 8'h00);
    wb({ADDR_FIXED, ~pin_hi, pin_lo, 1'b0}, 1'b1);
    act(ACT_START, 8'h00);
    wb({5'h0F, pin_hi, pin_lo, 1'b0}, 1'b1);
    act(ACT_STOP, 8'h00);
    chk("wiper1_live", 16'h00FE, {6'h00, w1});
  endtask

  // main sequence
  initial
  begin
    rstn = 1'b0;
    pin_hi = 1'b1;
    pin_lo = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 16'h0000;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (12) @(posedge clock);
    t_write;
    t_steps;
    t_illegal;
    t_locks;
    t_nv;
    t_read;
    t_abort;
    give_verdict;
  end
endmodule
